// ---- shared/edio_defs.vh ----
`ifndef EDIO_DEFS_VH
`define EDIO_DEFS_VH
// Timing
`define EDIO_CLK_HZ 20000000
`define EDIO_CYCLE_MS 100
`define EDIO_TICK_CYCLES (`EDIO_CLK_HZ / 1000 * `EDIO_CYCLE_MS)
`define EDIO_TICKS_PER_SEC (1000 / `EDIO_CYCLE_MS)
// Byte offsets
`define EDIO_OFS_CTRL 12'h000
`define EDIO_OFS_STATUS 12'h004
`define EDIO_OFS_CMD 12'h008
`define EDIO_OFS_OCFG 12'h040
`define EDIO_OFS_OSET 12'h080
`define EDIO_OFS_ICFG 12'h0c0
// Field positions
`define EDIO_CTRL_POT 0
`define EDIO_CTRL_COMM 1
`define EDIO_OCFG_NC 5
// Reset values
`define EDIO_OCFG_RST 32'h00000001
`define EDIO_OSET_RST 32'h00010000
`define EDIO_ICFG_RST 4'h1
// Output source codes
`define EDIO_SRC_NONE 5'h01
`define EDIO_SRC_DEVHI 5'h02
`define EDIO_SRC_DEVLO 5'h03
`define EDIO_SRC_DEVOUT 5'h04
`define EDIO_SRC_DEVIN 5'h05
`define EDIO_SRC_PVHI 5'h06
`define EDIO_SRC_PVLO 5'h07
`define EDIO_SRC_SO 5'h08
`define EDIO_SRC_FIX 5'h09
`define EDIO_SRC_AT 5'h0a
`define EDIO_SRC_MAN 5'h0b
`define EDIO_SRC_LOGIC 5'h0c
`define EDIO_SRC_RUN 5'h0d
`define EDIO_SRC_HOLD 5'h0e
`define EDIO_SRC_GUA 5'h0f
`define EDIO_SRC_STEP 5'h10
`define EDIO_SRC_END 5'h11
`define EDIO_SRC_TS1 5'h12
`define EDIO_SRC_TS8 5'h19
`define EDIO_SRC_DIRECT 5'h1a
`define EDIO_SRC_POSH 5'h1b
`define EDIO_SRC_POSL 5'h1c
`define EDIO_SRC_POTER 5'h1d
// Input function codes
`define EDIO_FN_RUNRST 4'h2
`define EDIO_FN_RST 4'h3
`define EDIO_FN_HOLD 4'h4
`define EDIO_FN_ADV 4'h5
`define EDIO_FN_FIX 4'h6
`define EDIO_FN_MAN 4'h7
`define EDIO_FN_LOGIC 4'h8
`define EDIO_FN_PTN2 4'h9
`define EDIO_FN_PTN5 4'hc
`define EDIO_FN_PRESET 4'hd
// Setting limits
`define EDIO_DEV_MAX 18'sd25000
`define EDIO_POS_MAX 18'sd100
`define EDIO_HYS_MAX 14'd9999
`define EDIO_DLY_MAX 14'd9999
`endif

// ---- logic/edio_event_io.v ----
// Notes on behaviour
// - Three event outputs refreshed every 100 ms
// - Each output has one source; 1 idles
// - Four deviation alarms, limits +-25000
// - Band limit for in/out is 0..25000
// - Scale-over source follows input over-range
// - Time signals 1-8 drive outputs directly
// - Direct source refused on event outputs
// - Positioning sources need potentiometer; 0..100
// - Alarm hysteresis 1..9999 units
// - Alarm action delay off or 1..9999 s
// - Standby modes 1 and 2 arm suppression
// - Standby mode 3 blanks alarm on scale-over
// - Per-output normally open/closed polarity
// - Nine discrete outputs share the scheme
// - Logic source only on event outputs and discrete outputs 1-5
// - Direct source on outputs 6-9 with comm
// - Ten discrete inputs, one function each
// - Run/reset level and forced reset
// - Hold suspends; advance steps program
// - Fixed mode and manual selection inputs
// - Pattern select from 2-5 inputs, capped
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "edio_defs.vh"
module edio_event_io #(
	parameter TICK_CYCLES = `EDIO_TICK_CYCLES
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Controller status
	input wire signed [15:0] measured_value,
	input wire signed [15:0] setpoint_value,
	input wire [7:0] position_pct,
	input wire scale_over,
	input wire fix_mode,
	input wire autotune,
	input wire manual_mode,
	input wire run_state,
	input wire hold_state,
	input wire guarantee_soak,
	input wire step_move,
	input wire program_end,
	input wire [7:0] time_signal,
	input wire [7:0] logic_out,
	input wire [3:0] direct_out,
	input wire potentiometer_error,
	// Discrete contacts
	input wire [9:0] discrete_control_input,
	// Output pins
	output wire [2:0] event_output,
	output wire [8:0] discrete_output,
	// Decoded commands
	output reg cmd_run,
	output reg cmd_force_reset,
	output reg program_hold,
	output reg step_advance,
	output reg cmd_fix,
	output reg manual_control,
	output reg [9:0] logic_input,
	output reg [4:0] start_pattern,
	output reg [2:0] preset_sel
);
	// Loop indices, one per process so no variable has two drivers
	integer i;
	integer oi;
	integer pi;
	integer bi;
	// Register file
	reg [1:0] ctrl_q;
	reg [31:0] ocfg_q [0:11];
	reg [31:0] oset_q [0:11];
	reg [3:0] icfg_q [0:9];
	// Bus answer flops
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	// Cycle timing
	reg [21:0] tick_cnt_q;
	reg tick_q;
	reg [3:0] sec_cnt_q;
	// Alarm state per output
	reg [11:0] alarm_q;
	reg [11:0] stby_q;
	reg [11:0] out_q;
	reg [13:0] dly_q [0:11];
	reg run_prev_q;
	reg signed [15:0] sv_prev_q;
	reg [9:0] di_q;
	reg adv_prev_q;
	// Combinational helpers
	reg [11:0] raw_c;
	reg [4:0] src_c;
	reg [4:0] ts_c;
	reg signed [17:0] lim_c;
	reg signed [17:0] hys_c;
	reg [3:0] fn_c;
	reg [2:0] pw_c;
	reg [2:0] pn_c;
	reg [4:0] pv_c;
	reg wr_ok_c;
	reg [31:0] rd_c;
	reg hit_c;
	reg [3:0] idx_c;
	wire signed [17:0] pv18 = {{2{measured_value[15]}}, measured_value};
	wire signed [17:0] dev18 = pv18 - {{2{setpoint_value[15]}}, setpoint_value};
	wire signed [17:0] adev18 = dev18[17] ? -dev18 : dev18;
	wire signed [17:0] pos18 = {10'h000, position_pct};
	wire [11:0] logic_vec = {4'h0, logic_out};
	wire [11:0] direct_vec = {direct_out, 8'h00};
	wire sec_tick = tick_q && (sec_cnt_q == 4'h0);
	// Preset contacts sit on inputs 2 to 4
	wire [9:0] preset_hits = fn_hits(`EDIO_FN_PRESET);

	// High-going comparison with hysteresis below the limit
	function hi_hit;
		input signed [17:0] x;
		input signed [17:0] lim;
		input signed [17:0] hys;
		input prev;
		begin
			hi_hit = prev ? (x > lim - hys) : (x >= lim);
		end
	endfunction

	// Low-going comparison with hysteresis above the limit
	function lo_hit;
		input signed [17:0] x;
		input signed [17:0] lim;
		input signed [17:0] hys;
		input prev;
		begin
			lo_hit = prev ? (x < lim + hys) : (x <= lim);
		end
	endfunction

	// Sources that take hysteresis, delay and standby
	function is_alarm;
		input [4:0] s;
		begin
			is_alarm = (s >= `EDIO_SRC_DEVHI && s <= `EDIO_SRC_PVLO) ||
				s == `EDIO_SRC_POSH || s == `EDIO_SRC_POSL;
		end
	endfunction

	// Source code legality for one output slot
	function src_ok;
		input [3:0] slot;
		input [4:0] s;
		input [1:0] ctrl;
		begin
			src_ok = (s >= `EDIO_SRC_NONE) && (s <= `EDIO_SRC_POTER);
			if (s == `EDIO_SRC_DIRECT) begin
				src_ok = (slot >= 4'd8) && ctrl[`EDIO_CTRL_COMM];
			end
			if (s == `EDIO_SRC_LOGIC) begin
				src_ok = (slot < 4'd8);
			end
			if (s >= `EDIO_SRC_POSH && s <= `EDIO_SRC_POTER) begin
				src_ok = ctrl[`EDIO_CTRL_POT];
			end
		end
	endfunction

	// Setting legality against the slot's current source
	function set_ok;
		input [4:0] s;
		input [31:0] w;
		reg signed [17:0] l;
		begin
			l = {{2{w[15]}}, w[15:0]};
			set_ok = (w[29:16] >= 14'd1) && (w[29:16] <= `EDIO_HYS_MAX);
			if (s == `EDIO_SRC_DEVHI || s == `EDIO_SRC_DEVLO) begin
				set_ok = set_ok && (l >= -`EDIO_DEV_MAX) && (l <= `EDIO_DEV_MAX);
			end
			if (s == `EDIO_SRC_DEVOUT || s == `EDIO_SRC_DEVIN) begin
				set_ok = set_ok && (l >= 18'sd0) && (l <= `EDIO_DEV_MAX);
			end
			if (s == `EDIO_SRC_POSH || s == `EDIO_SRC_POSL) begin
				set_ok = set_ok && (l >= 18'sd0) && (l <= `EDIO_POS_MAX);
			end
		end
	endfunction

	// Source evaluation for all twelve outputs
	always @* begin
		raw_c = 12'h000;
		src_c = 5'h00;
		ts_c = 5'h00;
		lim_c = 18'sd0;
		hys_c = 18'sd0;
		for (i = 0; i < 12; i = i + 1) begin
			src_c = ocfg_q[i][4:0];
			ts_c = src_c - `EDIO_SRC_TS1;
			lim_c = {{2{oset_q[i][15]}}, oset_q[i][15:0]};
			hys_c = {4'h0, oset_q[i][29:16]};
			case (src_c)
				`EDIO_SRC_DEVHI: raw_c[i] = hi_hit(dev18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_DEVLO: raw_c[i] = lo_hit(dev18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_DEVOUT: raw_c[i] = hi_hit(adev18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_DEVIN: raw_c[i] = lo_hit(adev18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_PVHI: raw_c[i] = hi_hit(pv18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_PVLO: raw_c[i] = lo_hit(pv18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_SO: raw_c[i] = scale_over;
				`EDIO_SRC_FIX: raw_c[i] = fix_mode;
				`EDIO_SRC_AT: raw_c[i] = autotune;
				`EDIO_SRC_MAN: raw_c[i] = manual_mode;
				`EDIO_SRC_LOGIC: raw_c[i] = logic_vec[i];
				`EDIO_SRC_RUN: raw_c[i] = run_state;
				`EDIO_SRC_HOLD: raw_c[i] = hold_state;
				`EDIO_SRC_GUA: raw_c[i] = guarantee_soak;
				`EDIO_SRC_STEP: raw_c[i] = step_move;
				`EDIO_SRC_END: raw_c[i] = program_end;
				`EDIO_SRC_DIRECT: raw_c[i] = direct_vec[i];
				`EDIO_SRC_POSH: raw_c[i] = hi_hit(pos18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_POSL: raw_c[i] = lo_hit(pos18, lim_c, hys_c, alarm_q[i]);
				`EDIO_SRC_POTER: raw_c[i] = potentiometer_error;
				default: begin
					if (src_c >= `EDIO_SRC_TS1 && src_c <= `EDIO_SRC_TS8) begin
						raw_c[i] = time_signal[ts_c[2:0]];
					end
				end
			endcase
		end
	end

	// Free-running 100 ms tick and seconds prescaler
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 22'h000000;
			tick_q <= 1'b0;
			sec_cnt_q <= 4'h0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_CYCLES - 1);
			if (tick_cnt_q == TICK_CYCLES - 1) begin
				tick_cnt_q <= 22'h000000;
			end else begin
				tick_cnt_q <= tick_cnt_q + 22'h000001;
			end
			if (tick_q) begin
				sec_cnt_q <= (sec_cnt_q == `EDIO_TICKS_PER_SEC - 1) ? 4'h0 : sec_cnt_q + 4'h1;
			end
		end
	end

	// Output refresh once per cycle; standby armed at power-on
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 12'h000;
			stby_q <= 12'hfff;
			out_q <= 12'h000;
			run_prev_q <= 1'b0;
			sv_prev_q <= 16'sh0000;
			for (oi = 0; oi < 12; oi = oi + 1) begin
				dly_q[oi] <= 14'h0000;
			end
		end else if (tick_q) begin
			run_prev_q <= run_state;
			sv_prev_q <= setpoint_value;
			for (oi = 0; oi < 12; oi = oi + 1) begin
				if (raw_c[oi] == alarm_q[oi]) begin
					dly_q[oi] <= 14'h0000;
				end else if (!is_alarm(ocfg_q[oi][4:0]) || ocfg_q[oi][21:8] == 14'h0000 ||
					dly_q[oi] >= ocfg_q[oi][21:8]) begin
					alarm_q[oi] <= raw_c[oi];
					dly_q[oi] <= 14'h0000;
				end else if (sec_tick) begin
					dly_q[oi] <= dly_q[oi] + 14'h0001;
				end
				if ((ocfg_q[oi][7:6] == 2'd1 || ocfg_q[oi][7:6] == 2'd2) &&
					run_state && !run_prev_q) begin
					stby_q[oi] <= 1'b1;
				end else if (ocfg_q[oi][7:6] == 2'd2 && setpoint_value != sv_prev_q) begin
					stby_q[oi] <= 1'b1;
				end else if (!raw_c[oi]) begin
					stby_q[oi] <= 1'b0;
				end
				out_q[oi] <= ocfg_q[oi][`EDIO_OCFG_NC] ^ (alarm_q[oi] &&
					!(is_alarm(ocfg_q[oi][4:0]) && stby_q[oi] &&
					(ocfg_q[oi][7:6] == 2'd1 || ocfg_q[oi][7:6] == 2'd2)) &&
					!(is_alarm(ocfg_q[oi][4:0]) && ocfg_q[oi][7:6] == 2'd3 && scale_over));
			end
		end
	end

	// Discrete inputs sampled and decoded on the tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			di_q <= 10'h000;
			adv_prev_q <= 1'b0;
			cmd_run <= 1'b0;
			cmd_force_reset <= 1'b0;
			program_hold <= 1'b0;
			step_advance <= 1'b0;
			cmd_fix <= 1'b0;
			manual_control <= 1'b0;
			logic_input <= 10'h000;
			start_pattern <= 5'h00;
			preset_sel <= 3'h0;
		end else begin
			// Advance is a one-clock pulse per rising contact
			step_advance <= 1'b0;
			if (tick_q) begin
				di_q <= discrete_control_input;
				adv_prev_q <= |(fn_hits(`EDIO_FN_ADV));
				cmd_run <= |(fn_hits(`EDIO_FN_RUNRST));
				cmd_force_reset <= |(fn_hits(`EDIO_FN_RST));
				program_hold <= |(fn_hits(`EDIO_FN_HOLD));
				step_advance <= |(fn_hits(`EDIO_FN_ADV)) && !adv_prev_q;
				cmd_fix <= |(fn_hits(`EDIO_FN_FIX));
				manual_control <= |(fn_hits(`EDIO_FN_MAN));
				logic_input <= fn_hits(`EDIO_FN_LOGIC);
				start_pattern <= pv_c;
				preset_sel <= preset_hits[3:1];
			end
		end
	end

	function [9:0] fn_hits;
		input [3:0] fn;
		integer k;
		begin
			for (k = 0; k < 10; k = k + 1) begin
				fn_hits[k] = (icfg_q[k] == fn) && discrete_control_input[k];
			end
		end
	endfunction

	// Pattern bits from first assigned width
	always @* begin
		pw_c = 3'h0;
		pn_c = 3'h0;
		pv_c = 5'h00;
		fn_c = 4'h0;
		for (pi = 0; pi < 10; pi = pi + 1) begin
			fn_c = icfg_q[pi];
			if (fn_c >= `EDIO_FN_PTN2 && fn_c <= `EDIO_FN_PTN5) begin
				// Codes 9..12 give widths 2..5
				if (pw_c == 3'h0) begin
					pw_c = fn_c[2:0] + 3'h1;
				end
				if (pn_c < pw_c) begin
					pv_c[pn_c] = discrete_control_input[pi];
					pn_c = pn_c + 3'h1;
				end
			end
		end
		// Above the width's ceiling selects nothing
		if ((pw_c == 3'h2 && pv_c > 5'd3) || (pw_c == 3'h5 && pv_c > 5'd20)) begin
			pv_c = 5'h00;
		end
	end

	// Bus decode, read mux and write legality
	always @* begin
		rd_c = 32'h00000000;
		hit_c = 1'b1;
		wr_ok_c = 1'b1;
		idx_c = paddr[5:2];
		if (paddr == `EDIO_OFS_CTRL) begin
			rd_c = {30'h0, ctrl_q};
		end else if (paddr == `EDIO_OFS_STATUS) begin
			rd_c = {5'h00, start_pattern, di_q, out_q};
			wr_ok_c = 1'b0;
		end else if (paddr == `EDIO_OFS_CMD) begin
			rd_c = {16'h0000, 4'h0, alarm_q};
			rd_c[20:12] = {preset_sel, manual_control, cmd_fix, program_hold,
				cmd_force_reset, cmd_run, step_advance};
			wr_ok_c = 1'b0;
		end else if (paddr[11:6] == 6'h01 && paddr[1:0] == 2'b00 && idx_c < 4'd12) begin
			rd_c = ocfg_q[idx_c];
			wr_ok_c = src_ok(idx_c, pwdata[4:0], ctrl_q) && pwdata[21:8] <= `EDIO_DLY_MAX;
		end else if (paddr[11:6] == 6'h02 && paddr[1:0] == 2'b00 && idx_c < 4'd12) begin
			rd_c = oset_q[idx_c];
			wr_ok_c = set_ok(ocfg_q[idx_c][4:0], pwdata);
		end else if (paddr[11:6] == 6'h03 && paddr[1:0] == 2'b00 && idx_c < 4'd10) begin
			rd_c = {28'h0, icfg_q[idx_c]};
			wr_ok_c = pwdata[3:0] >= 4'h1 && pwdata[3:0] <= `EDIO_FN_PRESET;
		end else begin
			hit_c = 1'b0;
		end
	end

	// APB slave: answer in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			ctrl_q <= 2'b00;
			for (bi = 0; bi < 12; bi = bi + 1) begin
				ocfg_q[bi] <= `EDIO_OCFG_RST;
				oset_q[bi] <= `EDIO_OSET_RST;
			end
			for (bi = 0; bi < 10; bi = bi + 1) begin
				icfg_q[bi] <= `EDIO_ICFG_RST;
			end
		end else begin
			pready_q <= psel && !penable;
			if (psel && !penable) begin
				prdata_q <= pwrite ? 32'h00000000 : rd_c;
				pslverr_q <= !hit_c || (pwrite && !wr_ok_c);
			end else begin
				// Answer stands one cycle only, so a stale error never leaks
				prdata_q <= 32'h00000000;
				pslverr_q <= 1'b0;
			end
			// Refused writes leave the register untouched
			if (psel && penable && pready_q && pwrite && !pslverr_q) begin
				if (paddr == `EDIO_OFS_CTRL) begin
					ctrl_q <= pwdata[1:0];
				end else if (paddr[11:6] == 6'h01) begin
					ocfg_q[idx_c] <= {10'h000, pwdata[21:0]};
				end else if (paddr[11:6] == 6'h02) begin
					oset_q[idx_c] <= {2'b00, pwdata[29:0]};
				end else if (paddr[11:6] == 6'h03) begin
					icfg_q[idx_c] <= pwdata[3:0];
				end
			end
		end
	end

	// Pins straight from flops
	assign event_output = out_q[2:0];
	assign discrete_output = out_q[11:3];
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
endmodule // edio_event_io

// ---- tb/edio_event_io_monitor.sv ----
`timescale 1ns/1ps
module edio_event_io_monitor #(
	parameter TICK_CYCLES = 20
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB answer side
	input wire psel,
	input wire penable,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Pins and commands
	input wire [2:0] event_output,
	input wire [8:0] discrete_output,
	input wire cmd_run,
	input wire cmd_force_reset,
	input wire program_hold,
	input wire step_advance,
	input wire cmd_fix,
	input wire manual_control,
	input wire [9:0] logic_input,
	input wire [4:0] start_pattern,
	input wire [2:0] preset_sel
);
	// Smallest age a move may show, one less than the tick spacing in clocks
	localparam int GAP = TICK_CYCLES - 1;
	// Last values and clocks since they moved
	reg [11:0] pins_q;
	reg [22:0] cmds_q;
	reg [15:0] pin_age_q;
	reg [15:0] cmd_age_q;
	wire [11:0] pins_d = {discrete_output, event_output};
	wire [22:0] cmds_d = {cmd_run, cmd_force_reset, program_hold, cmd_fix, manual_control,
		logic_input, start_pattern, preset_sel};
	wire ev_chg = pins_d[2:0] != pins_q[2:0];
	wire do_chg = pins_d[11:3] != pins_q[11:3];
	wire cmd_chg = cmds_d != cmds_q;
	// Ages saturate so a long quiet spell cannot wrap into a false alarm
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_q <= 12'h000;
			cmds_q <= 23'h000000;
			pin_age_q <= 16'h0000;
			cmd_age_q <= 16'h0000;
		end else begin
			pins_q <= pins_d;
			cmds_q <= cmds_d;
			pin_age_q <= (ev_chg || do_chg) ? 16'h0000 : pin_age_q + {15'h0000, &pin_age_q == 1'b0};
			cmd_age_q <= cmd_chg ? 16'h0000 : cmd_age_q + {15'h0000, &cmd_age_q == 1'b0};
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ev_tick; ev_chg |-> pin_age_q >= GAP; endproperty
	a_ev_tick: assert property (p_ev_tick) else $error("event pin moved between ticks");
	property p_do_tick; do_chg |-> pin_age_q >= GAP; endproperty
	a_do_tick: assert property (p_do_tick) else $error("output pin moved between ticks");
	property p_cmd_tick; cmd_chg |-> cmd_age_q >= GAP; endproperty
	a_cmd_tick: assert property (p_cmd_tick) else $error("command moved between ticks");
	property p_adv_pulse; step_advance |=> !step_advance [*8]; endproperty
	a_adv_pulse: assert property (p_adv_pulse) else $error("advance not a single pulse");
	property p_ptn_cap; start_pattern <= 5'h14; endproperty
	a_ptn_cap: assert property (p_ptn_cap) else $error("start pattern above twenty");
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
	property p_rdy_ans; psel && !penable |=> pready; endproperty
	a_rdy_ans: assert property (p_rdy_ans) else $error("no answer after setup");
	property p_err_zero; pslverr |-> pready && prdata == 32'h00000000; endproperty
	a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
	// Main scenarios reached
	c_err: cover property (pslverr);
	c_adv: cover property (step_advance);
	c_ptn: cover property (start_pattern == 5'h14);
endmodule // edio_event_io_monitor
bind edio_event_io edio_event_io_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .event_output(event_output),
	.discrete_output(discrete_output), .cmd_run(cmd_run), .cmd_force_reset(cmd_force_reset),
	.program_hold(program_hold), .step_advance(step_advance), .cmd_fix(cmd_fix),
	.manual_control(manual_control), .logic_input(logic_input),
	.start_pattern(start_pattern), .preset_sel(preset_sel));

// ---- tb/edio_contacts.sv ----
`timescale 1ns/1ps
module edio_contacts #(
	parameter HOLD_CYCLES = 20
) (
	// Clock
	input wire pclk,
	// Contacts toward the device
	output logic [9:0] contacts
);
	// Free clock count and the count at the last move
	integer cyc = 0;
	integer mark = 0;
	initial contacts = 10'h000;
	// Count clocks
	always @(posedge pclk) begin
		cyc <= cyc + 1;
	end
	// hold each level
	// A contact that moves again too soon could be missed by the sampler
	task automatic press(input logic [9:0] v);
		while (cyc - mark < HOLD_CYCLES) @(posedge pclk);
		contacts <= v;
		mark = cyc;
	endtask
endmodule // edio_contacts

// ---- tb/edio_event_io_bench.sv ----
`timescale 1ns/1ps
module edio_event_io_bench;
	// Short tick keeps the run brief
	localparam int TK = 20;
	// Address, data, refusal expected
	localparam logic [44:0] REF [16] = '{
		{12'h040, 32'h0000001a, 1'b1}, {12'h060, 32'h0000000c, 1'b1},
		{12'h060, 32'h0000001a, 1'b1}, {12'h040, 32'h0000001b, 1'b1},
		{12'h040, 32'h0000001e, 1'b1}, {12'h000, 32'h00000003, 1'b0},
		{12'h060, 32'h0000001a, 1'b0}, {12'h048, 32'h00000002, 1'b0},
		{12'h088, 32'h000161a9, 1'b1}, {12'h088, 32'h00019e58, 1'b0},
		{12'h088, 32'h27100000, 1'b1}, {12'h048, 32'h00271002, 1'b1},
		{12'h048, 32'h00000004, 1'b0}, {12'h088, 32'h0001ffff, 1'b1},
		{12'h040, 32'h0000001d, 1'b0}, {12'h0c0, 32'h0000000e, 1'b1}};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic signed [15:0] pv = 16'sh0000;
	logic signed [15:0] sv = 16'sh0000;
	logic so = 1'b0;
	logic poterr = 1'b0;
	logic [3:0] dout = 4'h0;
	logic [7:0] pos = 8'h00;
	// Time signals above the status flags
	logic [16:0] src_v = 17'h00000;
	logic last_e;
	wire [31:0] prdata;
	wire pready, pslverr, c_run, c_rst, c_hold, c_adv, c_fix, c_man;
	wire [9:0] di, lin;
	wire [2:0] ev, pre;
	wire [8:0] dio;
	wire [4:0] ptn;
	integer errors = 0;
	integer n_tests = 0;
	integer cyc = 0;
	integer adv_n = 0;
	edio_event_io #(.TICK_CYCLES(TK)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .measured_value(pv), .setpoint_value(sv),
		.position_pct(pos), .scale_over(so), .fix_mode(src_v[0]), .autotune(src_v[1]),
		.manual_mode(src_v[2]), .run_state(src_v[4]), .hold_state(src_v[5]),
		.guarantee_soak(src_v[6]), .step_move(src_v[7]), .program_end(src_v[8]),
		.time_signal(src_v[16:9]), .logic_out({7'h00, src_v[3]}), .direct_out(dout),
		.potentiometer_error(poterr), .discrete_control_input(di), .event_output(ev),
		.discrete_output(dio), .cmd_run(c_run), .cmd_force_reset(c_rst),
		.program_hold(c_hold), .step_advance(c_adv), .cmd_fix(c_fix),
		.manual_control(c_man), .logic_input(lin), .start_pattern(ptn), .preset_sel(pre));
	edio_contacts #(.HOLD_CYCLES(TK)) cont_u (.pclk(pclk), .contacts(di));
	always #25 pclk = ~pclk;
	// Hang guard and advance pulse count
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (c_adv === 1'b1) adv_n <= adv_n + 1;
		if (cyc == 40000) begin
			errors++;
			print_verdict;
		end
	end
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bit1(input logic s, input logic x);
		chk({31'h0, s}, {31'h0, x});
	endtask
	// One APB transfer; pready is sampled at the rising edge with the request still up
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		bit1(e, ee);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		apb(1'b0, a, 32'h00000000, r, last_e);
		chk(r, x);
	endtask
	task automatic ticks(input int n);
		repeat (n * TK) @(posedge pclk);
	endtask
	task automatic t_regs;
		rd(12'h040, 32'h00000001);
		rd(12'h080, 32'h00010000);
		rd(12'h0c0, 32'h00000001);
		rd(12'hffc, 32'h00000000);
		bit1(last_e, 1'b1);
		$display("t_regs done");
	endtask
	task automatic t_refuse;
		foreach (REF[i]) wr(REF[i][44:33], REF[i][32:1], REF[i][0]);
		rd(12'h048, 32'h00000004);
		rd(12'h060, 32'h0000001a);
		$display("t_refuse done");
	endtask
	task automatic t_sources;
		for (int c = 9; c < 26; c++) begin
			wr(12'h040, 32'(c), 1'b0);
			wr(12'h04c, 32'(c), 1'b0);
			src_v <= 17'h00001 << (c - 9);
			ticks(3);
			bit1(ev[0], 1'b1);
			bit1(dio[0], c != 12);
			src_v <= ~(17'h00001 << (c - 9));
			ticks(3);
			bit1(ev[0] | dio[0], 1'b0);
		end
		src_v <= 17'h00000;
		wr(12'h040, 32'h00000021, 1'b0);
		ticks(3);
		bit1(ev[0], 1'b1);
		wr(12'h040, 32'h0000001d, 1'b0);
		wr(12'h06c, 32'h0000001a, 1'b0);
		poterr <= 1'b1;
		dout <= 4'h8;
		ticks(3);
		bit1(ev[0], 1'b1);
		bit1(dio[8], 1'b1);
		$display("t_sources done");
	endtask
	task automatic t_dev;
		wr(12'h044, 32'h000000c2, 1'b0);
		wr(12'h084, 32'h00010064, 1'b0);
		wr(12'h048, 32'h00000008, 1'b0);
		ticks(2);
		pv <= 16'sh0096;
		ticks(3);
		bit1(ev[1], 1'b1);
		so <= 1'b1;
		ticks(3);
		bit1(ev[1], 1'b0);
		bit1(ev[2], 1'b1);
		so <= 1'b0;
		pv <= 16'sh0032;
		ticks(3);
		bit1(ev[1], 1'b0);
		wr(12'h044, 32'h00000005, 1'b0);
		wr(12'h084, 32'h00010064, 1'b0);
		ticks(3);
		bit1(ev[1], 1'b1);
		$display("t_dev done");
	endtask
	task automatic t_alarm;
		pos <= 8'h28;
		wr(12'h044, 32'h0000001b, 1'b0);
		wr(12'h084, 32'h00010032, 1'b0);
		ticks(3);
		bit1(ev[1], 1'b0);
		pos <= 8'h3c;
		ticks(3);
		bit1(ev[1], 1'b1);
		// One second of delay holds the pin past two refreshes
		wr(12'h044, 32'h0000011b, 1'b0);
		pos <= 8'h28;
		ticks(2);
		bit1(ev[1], 1'b1);
		ticks(13);
		bit1(ev[1], 1'b0);
		// Standby mode 1 re-armed by the run edge while the alarm stands
		wr(12'h044, 32'h0000005b, 1'b0);
		pos <= 8'h3c;
		ticks(3);
		bit1(ev[1], 1'b1);
		src_v <= 17'h00010;
		ticks(3);
		bit1(ev[1], 1'b0);
		pos <= 8'h28;
		ticks(3);
		pos <= 8'h3c;
		ticks(3);
		bit1(ev[1], 1'b1);
		src_v <= 17'h00000;
		$display("t_alarm done");
	endtask
	task automatic t_inputs;
		int n0;
		for (int i = 0; i < 10; i++) wr(12'h0c0 + 12'(4 * i), (i < 7) ? 32'(i + 2) : 32'h1, 1'b0);
		n0 = adv_n;
		cont_u.press(10'h07d);
		ticks(3);
		chk({26'h0, c_run, c_rst, c_hold, c_fix, c_man, lin[6]}, 32'h2f);
		cont_u.press(10'h002);
		ticks(3);
		chk({26'h0, c_run, c_rst, c_hold, c_fix, c_man, lin[6]}, 32'h10);
		chk(32'(adv_n - n0), 32'h00000001);
		for (int w = 2; w < 6; w++) begin
			for (int i = 0; i < 10; i++) wr(12'h0c0 + 12'(4 * i), (i < w) ? 32'(w + 7) : 32'h1, 1'b0);
			cont_u.press((w == 5) ? 10'h014 : 10'((1 << w) - 1));
			ticks(3);
			chk({27'h0, ptn}, (w == 5) ? 32'h14 : 32'((1 << w) - 1));
			cont_u.press(10'((1 << w) - 1));
			ticks(3);
			chk({27'h0, ptn}, (w == 5) ? 32'h0 : 32'((1 << w) - 1));
		end
		for (int i = 0; i < 10; i++) wr(12'h0c0 + 12'(4 * i), (i == 0) ? 32'h8 : (i < 4) ? 32'hd : 32'h1, 1'b0);
		cont_u.press(10'h00b);
		ticks(3);
		chk({28'h0, lin[0], pre}, 32'hd);
		$display("t_inputs done");
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_refuse;
		t_sources;
		t_dev;
		t_alarm;
		t_inputs;
		print_verdict;
	end
endmodule // edio_event_io_bench
